/* File: hdl/gnpf_pkg.sv */
// Package of packet identifiers, lengths, offsets and carrier types for the packet formatter
package gnpf_pkg;

    // ****************************************
    // Packet identifiers and payload lengths
    // ****************************************
    localparam logic [7:0] ID_RAW_RX     = 8'h1D;
    localparam logic [7:0] LEN_RAW_RX    = 8'h4A;
    localparam logic [7:0] ID_SATS       = 8'h1E;
    localparam logic [7:0] LEN_SATS      = 8'h0D;
    localparam logic [7:0] ID_GEO_POS    = 8'h20;
    localparam logic [7:0] LEN_GEO_POS   = 8'h18;
    localparam logic [7:0] ID_ECF_POS    = 8'h21;
    localparam logic [7:0] LEN_ECF_POS   = 8'h18;
    localparam logic [7:0] ID_GRID_POS   = 8'h22;
    localparam logic [7:0] LEN_GRID_POS  = 8'h1A;
    localparam logic [7:0] ID_LOCAL_VEL  = 8'h23;
    localparam logic [7:0] LEN_LOCAL_VEL = 8'h0C;

    // ****************************************
    // Raw receiver packet byte offsets
    // ****************************************
    localparam int OFS_SECONDS   = 0;
    localparam int OFS_MICROS    = 4;
    localparam int OFS_LAT       = 8;
    localparam int OFS_LON       = 16;
    localparam int OFS_HGT       = 24;
    localparam int OFS_VN        = 32;
    localparam int OFS_VE        = 36;
    localparam int OFS_VD        = 40;
    localparam int OFS_LAT_SD    = 44;
    localparam int OFS_LON_SD    = 48;
    localparam int OFS_HGT_SD    = 52;
    localparam int OFS_TILT      = 56;
    localparam int OFS_HEAD      = 60;
    localparam int OFS_TILT_SD   = 64;
    localparam int OFS_HEAD_SD   = 68;
    localparam int OFS_STATUS    = 72;

    // Satellites packet offsets
    localparam int OFS_HPD       = 0;
    localparam int OFS_VPD       = 4;
    localparam int OFS_SAT_CNT   = 8;
    localparam int NUM_SAT_SYS   = 5;
    // Grid packet offsets
    localparam int OFS_ZONE_NUM  = 24;
    localparam int OFS_ZONE_CHR  = 25;

    // Status word bit positions
    localparam int ST_FIX_LSB    = 0;
    localparam int ST_DOPPLER    = 3;
    localparam int ST_TIME       = 4;
    localparam int ST_EXT_RX     = 5;
    localparam int ST_TILT       = 6;
    localparam int ST_HEAD       = 7;
    localparam int ST_FLOAT_HEAD = 8;
    localparam int ST_RESERVED   = 9;
    localparam int ST_ANT1_DISC  = 10;
    localparam int ST_ANT2_DISC  = 11;
    localparam int ST_ANT1_SHORT = 12;
    localparam int ST_ANT2_SHORT = 13;
    localparam int ST_RX1_FAIL   = 14;
    localparam int ST_RX2_FAIL   = 15;

    localparam int MAX_LEN       = 74;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef enum logic [2:0] {
        GNPF_PKT_RAW_RX,
        GNPF_PKT_SATS,
        GNPF_PKT_GEO_POS,
        GNPF_PKT_ECF_POS,
        GNPF_PKT_GRID_POS,
        GNPF_PKT_LOCAL_VEL
    } gnpf_pkt_t;

    // Status sources from the receivers
    typedef struct packed {
        logic [2:0] fix_status;
        logic       doppler_valid;
        logic       time_valid;
        logic       external_rx;
        logic       tilt_valid;
        logic       heading_valid;
        logic       float_heading;
        logic       ant1_disc;
        logic       ant2_disc;
        logic       ant1_short;
        logic       ant2_short;
        logic       primary_receiver_fail;
        logic       secondary_receiver_fail;
    } gnpf_rx_status_t;

    // Raw receiver solution, uncorrected
    typedef struct packed {
        logic [31:0]     seconds;
        logic [31:0]     micros;
        logic [63:0]     lat;
        logic [63:0]     lon;
        logic [63:0]     hgt;
        logic [31:0]     vn;
        logic [31:0]     ve;
        logic [31:0]     vd;
        logic [31:0]     lat_sd;
        logic [31:0]     lon_sd;
        logic [31:0]     hgt_sd;
        logic [31:0]     tilt;
        logic [31:0]     heading;
        logic [31:0]     tilt_sd;
        logic [31:0]     heading_sd;
        gnpf_rx_status_t status;
    } gnpf_raw_rx_t;

    // Corrected inertial solution and satellite summary
    typedef struct packed {
        logic [31:0]     horizontal_precision_dilution;
        logic [31:0]     vertical_precision_dilution;
        logic [39:0]     sat_counts;
        logic [191:0]    geo_pos;
        logic [191:0]    earth_centred_frame_pos;
        logic [191:0]    grid_projection_pos;
        logic [7:0]      zone_num;
        logic [7:0]      zone_chr;
        logic [95:0]     north_east_down_frame_vel;
    } gnpf_sol_t;

    // Whole module state
    typedef struct packed {
        logic              busy;
        logic [7:0]        pkt_id;
        logic [7:0]        pkt_len;
        logic [7:0]        idx;
        logic [MAX_LEN*8-1:0] buf_bytes;
        logic [7:0]        data;
        logic              valid;
        logic              last;
    } gnpf_state_t;

endpackage

/* File: hdl/gnpf_formatter.sv */
// Navigation packet formatter: captures a packet payload and streams it bytewise
`timescale 1ns/1ps
`default_nettype none

module gnpf_formatter (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   req_valid_in,
    input  wire gnpf_pkg::gnpf_pkt_t    req_pkt_in,
    output logic                        req_ready_out,
    input  wire gnpf_pkg::gnpf_raw_rx_t raw_rx_in,
    input  wire gnpf_pkg::gnpf_sol_t    inertial_solution_in,
    output logic [7:0]                  pkt_id_out,
    output logic [7:0]                  pkt_len_out,
    output logic [7:0]                  byte_data_out,
    output logic [7:0]                  byte_index_out,
    output logic                        byte_valid_out,
    output logic                        byte_last_out,
    input  wire logic                   byte_ready_in
);

    localparam int BW = gnpf_pkg::MAX_LEN * 8;

    gnpf_pkg::gnpf_state_t state_reg;
    gnpf_pkg::gnpf_state_t state_next;

    // Place a value little-endian at a byte offset
    function automatic logic [BW-1:0] put(input logic [BW-1:0] b, input int ofs,
                                          input logic [63:0] v, input int nbytes);
        logic [BW-1:0] r;
        r = b;
        for (int i = 0; i < 8; i++) begin
            if (i < nbytes) begin
                r[(ofs+i)*8 +: 8] = v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Build the receiver status word
    function automatic logic [15:0] status_word(input gnpf_pkg::gnpf_rx_status_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[gnpf_pkg::ST_FIX_LSB +: 3]      = s.fix_status;
        w[gnpf_pkg::ST_DOPPLER]           = s.doppler_valid;
        w[gnpf_pkg::ST_TIME]              = s.time_valid;
        w[gnpf_pkg::ST_EXT_RX]            = s.external_rx;
        w[gnpf_pkg::ST_TILT]              = s.tilt_valid;
        w[gnpf_pkg::ST_HEAD]              = s.heading_valid;
        w[gnpf_pkg::ST_FLOAT_HEAD]        = s.float_heading;
        w[gnpf_pkg::ST_RESERVED]          = 1'h0;
        w[gnpf_pkg::ST_ANT1_DISC]         = s.ant1_disc;
        w[gnpf_pkg::ST_ANT2_DISC]         = s.ant2_disc;
        w[gnpf_pkg::ST_ANT1_SHORT]        = s.ant1_short;
        w[gnpf_pkg::ST_ANT2_SHORT]        = s.ant2_short;
        w[gnpf_pkg::ST_RX1_FAIL]          = s.primary_receiver_fail;
        w[gnpf_pkg::ST_RX2_FAIL]          = s.secondary_receiver_fail;
        return w;
    endfunction

    // Snapshot of the receiver packet, raw values unaltered
    function automatic logic [BW-1:0] build_raw(input gnpf_pkg::gnpf_raw_rx_t r);
        logic [BW-1:0] b;
        b = '0;
        b = put(b, gnpf_pkg::OFS_SECONDS, {32'h0, r.seconds}, 4);
        b = put(b, gnpf_pkg::OFS_MICROS, {32'h0, r.micros}, 4);
        b = put(b, gnpf_pkg::OFS_LAT, r.lat, 8);
        b = put(b, gnpf_pkg::OFS_LON, r.lon, 8);
        b = put(b, gnpf_pkg::OFS_HGT, r.hgt, 8);
        b = put(b, gnpf_pkg::OFS_VN, {32'h0, r.vn}, 4);
        b = put(b, gnpf_pkg::OFS_VE, {32'h0, r.ve}, 4);
        b = put(b, gnpf_pkg::OFS_VD, {32'h0, r.vd}, 4);
        b = put(b, gnpf_pkg::OFS_LAT_SD, {32'h0, r.lat_sd}, 4);
        b = put(b, gnpf_pkg::OFS_LON_SD, {32'h0, r.lon_sd}, 4);
        b = put(b, gnpf_pkg::OFS_HGT_SD, {32'h0, r.hgt_sd}, 4);
        b = put(b, gnpf_pkg::OFS_TILT, {32'h0, r.tilt}, 4);
        b = put(b, gnpf_pkg::OFS_TILT_SD, {32'h0, r.tilt_sd}, 4);
        b = put(b, gnpf_pkg::OFS_HEAD, {32'h0, r.heading}, 4);
        b = put(b, gnpf_pkg::OFS_HEAD_SD, {32'h0, r.heading_sd}, 4);
        b = put(b, gnpf_pkg::OFS_STATUS, {48'h0, status_word(r.status)}, 2);
        return b;
    endfunction

    // Place three consecutive words of a given size from offset zero
    function automatic logic [BW-1:0] build_triple(input logic [191:0] v, input int nbytes);
        logic [BW-1:0] b;
        b = '0;
        for (int k = 0; k < 3; k++) begin
            b = put(b, k * nbytes, v[k*64 +: 64], nbytes);
        end
        return b;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [191:0] vel3;
        vel3 = '0;
        state_next = state_reg;
        state_next.valid = state_reg.busy;
        if (state_reg.busy && byte_ready_in) begin
            if (state_reg.idx == state_reg.pkt_len - 8'h01) begin
                state_next.busy  = 1'b0;
                state_next.valid = 1'b0;
            end else begin
                state_next.idx = state_reg.idx + 8'h01;
            end
        end
        if (!state_reg.busy && req_valid_in) begin
            state_next.busy  = 1'b1;
            state_next.valid = 1'b1;
            state_next.idx   = 8'h00;
            case (req_pkt_in)
                gnpf_pkg::GNPF_PKT_RAW_RX: begin
                    state_next.pkt_id    = gnpf_pkg::ID_RAW_RX;
                    state_next.pkt_len   = gnpf_pkg::LEN_RAW_RX;
                    state_next.buf_bytes = build_raw(raw_rx_in);
                end
                gnpf_pkg::GNPF_PKT_SATS: begin
                    state_next.pkt_id    = gnpf_pkg::ID_SATS;
                    state_next.pkt_len   = gnpf_pkg::LEN_SATS;
                    state_next.buf_bytes = put('0, gnpf_pkg::OFS_HPD,
                        {32'h0, inertial_solution_in.horizontal_precision_dilution}, 4);
                    state_next.buf_bytes = put(state_next.buf_bytes, gnpf_pkg::OFS_VPD,
                        {32'h0, inertial_solution_in.vertical_precision_dilution}, 4);
                    state_next.buf_bytes = put(state_next.buf_bytes, gnpf_pkg::OFS_SAT_CNT,
                        {24'h0, inertial_solution_in.sat_counts}, gnpf_pkg::NUM_SAT_SYS);
                end
                gnpf_pkg::GNPF_PKT_GEO_POS: begin
                    state_next.pkt_id    = gnpf_pkg::ID_GEO_POS;
                    state_next.pkt_len   = gnpf_pkg::LEN_GEO_POS;
                    state_next.buf_bytes = build_triple(inertial_solution_in.geo_pos, 8);
                end
                gnpf_pkg::GNPF_PKT_ECF_POS: begin
                    state_next.pkt_id    = gnpf_pkg::ID_ECF_POS;
                    state_next.pkt_len   = gnpf_pkg::LEN_ECF_POS;
                    state_next.buf_bytes = build_triple(
                        inertial_solution_in.earth_centred_frame_pos, 8);
                end
                gnpf_pkg::GNPF_PKT_GRID_POS: begin
                    state_next.pkt_id    = gnpf_pkg::ID_GRID_POS;
                    state_next.pkt_len   = gnpf_pkg::LEN_GRID_POS;
                    state_next.buf_bytes = build_triple(
                        inertial_solution_in.grid_projection_pos, 8);
                    state_next.buf_bytes = put(state_next.buf_bytes, gnpf_pkg::OFS_ZONE_NUM,
                        {56'h0, inertial_solution_in.zone_num}, 1);
                    state_next.buf_bytes = put(state_next.buf_bytes, gnpf_pkg::OFS_ZONE_CHR,
                        {56'h0, inertial_solution_in.zone_chr}, 1);
                end
                gnpf_pkg::GNPF_PKT_LOCAL_VEL: begin
                    for (int k = 0; k < 3; k++) begin
                        vel3[k*64 +: 32] =
                            inertial_solution_in.north_east_down_frame_vel[k*32 +: 32];
                    end
                    state_next.pkt_id    = gnpf_pkg::ID_LOCAL_VEL;
                    state_next.pkt_len   = gnpf_pkg::LEN_LOCAL_VEL;
                    state_next.buf_bytes = build_triple(vel3, 4);
                end
                default: begin
                    state_next.busy  = 1'b0;
                    state_next.valid = 1'b0;
                end
            endcase
        end
        state_next.data = state_next.buf_bytes[state_next.idx*8 +: 8];
        state_next.last = state_next.busy && (state_next.idx == state_next.pkt_len - 8'h01);
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign req_ready_out  = !state_reg.busy;
    assign pkt_id_out     = state_reg.pkt_id;
    assign pkt_len_out    = state_reg.pkt_len;
    assign byte_data_out  = state_reg.data;
    assign byte_index_out = state_reg.idx;
    assign byte_valid_out = state_reg.valid;
    assign byte_last_out  = state_reg.last;

    // ****************************************
    // Checks
    // ****************************************
    raw_id_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (req_valid_in && req_ready_out && req_pkt_in == gnpf_pkg::GNPF_PKT_RAW_RX)
        |=> (pkt_id_out == 8'h1D && pkt_len_out == 8'h4A))
        else $error("raw packet id or length wrong");
    reserved_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_valid_out && pkt_id_out == 8'h1D && byte_index_out == 8'h49)
        |-> !byte_data_out[1])
        else $error("status bit 9 not zero");
    status_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (req_valid_in && req_ready_out && req_pkt_in == gnpf_pkg::GNPF_PKT_RAW_RX)
        |=> state_reg.buf_bytes[72*8 +: 3] == $past(raw_rx_in.status.fix_status))
        else $error("fix status misplaced");
    fail_bits_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (req_valid_in && req_ready_out && req_pkt_in == gnpf_pkg::GNPF_PKT_RAW_RX)
        |=> state_reg.buf_bytes[73*8+6 +: 2] == {$past(raw_rx_in.status.secondary_receiver_fail),
                                                 $past(raw_rx_in.status.primary_receiver_fail)})
        else $error("failure bits misplaced");
    last_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_valid_out && byte_last_out) |-> byte_index_out == pkt_len_out - 8'h01)
        else $error("last byte index wrong");
    sat_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (req_valid_in && req_ready_out && req_pkt_in == gnpf_pkg::GNPF_PKT_SATS)
        |=> (pkt_id_out == 8'h1E && pkt_len_out == 8'h0D))
        else $error("satellites packet header wrong");
    grid_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (req_valid_in && req_ready_out && req_pkt_in == gnpf_pkg::GNPF_PKT_GRID_POS)
        |=> (pkt_id_out == 8'h22 && pkt_len_out == 8'h1A))
        else $error("grid packet header wrong");
    hold_byte_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_valid_out && !byte_ready_in) |=> (byte_valid_out && $stable(byte_index_out)))
        else $error("byte dropped under stall");
    raw_cov_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        byte_valid_out && byte_last_out && pkt_id_out == 8'h1D);
    sat_cov_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        byte_valid_out && byte_last_out && pkt_id_out == 8'h1E);
    stall_cov_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        byte_valid_out && !byte_ready_in);

endmodule

`default_nettype wire

/* File: testbench/gnpf_host_model.sv */
// Host-side byte sink for the packet formatter, with optional stalling
`timescale 1ns/1ps
`default_nettype none

module gnpf_host_model (
    input  wire logic                         clk_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         stall_in,
    input  wire logic [7:0]                   byte_data_in,
    input  wire logic [7:0]                   byte_index_in,
    input  wire logic                         byte_valid_in,
    output logic                              byte_ready_out,
    output logic [7:0]                        count_out,
    output logic [gnpf_pkg::MAX_LEN*8-1:0]    bytes_out
);
    // Store each accepted byte at its offset; ready toggles when stalling
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_ready_out <= 1'h0;
            count_out      <= 8'h00;
            bytes_out      <= '0;
        end else begin
            byte_ready_out <= stall_in ? ~byte_ready_out : 1'h1;
            if (byte_valid_in && byte_ready_out) begin
                bytes_out[byte_index_in*8+:8] <= byte_data_in;
                count_out <= (byte_index_in == 8'h00) ? 8'h01 : count_out + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

/* File: testbench/gnpf_formatter_tb_top.sv */
// Self-checking bench for the navigation packet formatter
`timescale 1ns/1ps
`default_nettype none

module gnpf_formatter_tb_top;
    // ****************************************
    // Signals and stimulus table
    // ****************************************
    typedef struct packed {
        gnpf_pkg::gnpf_pkt_t kind;
        logic [7:0]          id;
        logic [7:0]          len;
        logic                stall;
    } gnpf_row_t;

    logic                                  clk_in, rst_n_in, req_valid_in, req_ready_out;
    logic                                  byte_valid_out, byte_last_out, byte_ready_in;
    logic                                  host_stall;
    gnpf_pkg::gnpf_pkt_t                   req_pkt_in;
    gnpf_pkg::gnpf_raw_rx_t                raw_rx_in;
    gnpf_pkg::gnpf_sol_t                   inertial_solution_in;
    logic [7:0]                            pkt_id_out, pkt_len_out, byte_data_out;
    logic [7:0]                            byte_index_out, host_cnt;
    logic [gnpf_pkg::MAX_LEN*8-1:0]        host_bytes;
    logic [7:0]                            exp_q [$];
    int                                    err_total, checked, last_seen;
    gnpf_row_t                             rows [6] = '{
        '{gnpf_pkg::GNPF_PKT_RAW_RX, gnpf_pkg::ID_RAW_RX, gnpf_pkg::LEN_RAW_RX, 1'h1},
        '{gnpf_pkg::GNPF_PKT_SATS, gnpf_pkg::ID_SATS, gnpf_pkg::LEN_SATS, 1'h0},
        '{gnpf_pkg::GNPF_PKT_GEO_POS, gnpf_pkg::ID_GEO_POS, gnpf_pkg::LEN_GEO_POS, 1'h1},
        '{gnpf_pkg::GNPF_PKT_ECF_POS, gnpf_pkg::ID_ECF_POS, gnpf_pkg::LEN_ECF_POS, 1'h0},
        '{gnpf_pkg::GNPF_PKT_GRID_POS, gnpf_pkg::ID_GRID_POS, gnpf_pkg::LEN_GRID_POS, 1'h1},
        '{gnpf_pkg::GNPF_PKT_LOCAL_VEL, gnpf_pkg::ID_LOCAL_VEL, gnpf_pkg::LEN_LOCAL_VEL, 1'h0}};

    gnpf_formatter i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_pkt_in(req_pkt_in), .req_ready_out(req_ready_out), .raw_rx_in(raw_rx_in),
        .inertial_solution_in(inertial_solution_in), .pkt_id_out(pkt_id_out),
        .pkt_len_out(pkt_len_out),
        .byte_data_out(byte_data_out), .byte_index_out(byte_index_out),
        .byte_valid_out(byte_valid_out), .byte_last_out(byte_last_out),
        .byte_ready_in(byte_ready_in));

    gnpf_host_model i_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(host_stall),
        .byte_data_in(byte_data_out), .byte_index_in(byte_index_out),
        .byte_valid_in(byte_valid_out), .byte_ready_out(byte_ready_in),
        .count_out(host_cnt), .bytes_out(host_bytes));

    // 125 MHz clock
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end

    // Count last-byte markers taken by the host
    always @(negedge clk_in) begin
        if (byte_valid_out === 1'h1 && byte_ready_in === 1'h1 && byte_last_out === 1'h1) begin
            last_seen++;
        end
    end

    // ****************************************
    // Helper tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Append a value little-endian
    task automatic put(input logic [63:0] v, input int nb);
        for (int i = 0; i < nb; i++) exp_q.push_back(v[i*8+:8]);
    endtask

    // Varied bit pattern on both value sources
    task automatic fill(input int pat);
        for (int b = 0; b < $bits(raw_rx_in); b++) raw_rx_in[b] = ((b * b + pat) % 5) < 2;
        for (int b = 0; b < $bits(inertial_solution_in); b++) begin
            inertial_solution_in[b] = ((b * b + pat) % 7) < 3;
        end
    endtask

    // Expected payload from the current inputs
    task automatic build(input gnpf_pkg::gnpf_pkt_t k);
        gnpf_pkg::gnpf_rx_status_t s;
        logic [191:0]              tri3;
        exp_q.delete();
        s = raw_rx_in.status;
        tri3 = (k == gnpf_pkg::GNPF_PKT_GEO_POS) ? inertial_solution_in.geo_pos :
               (k == gnpf_pkg::GNPF_PKT_ECF_POS) ? inertial_solution_in.earth_centred_frame_pos :
               inertial_solution_in.grid_projection_pos;
        case (k)
            gnpf_pkg::GNPF_PKT_RAW_RX: begin
                put(raw_rx_in.seconds, 4);
                put(raw_rx_in.micros, 4);
                put(raw_rx_in.lat, 8);
                put(raw_rx_in.lon, 8);
                put(raw_rx_in.hgt, 8);
                for (int j = 9; j >= 0; j--) put(raw_rx_in[15+j*32+:32], 4);
                put({s.secondary_receiver_fail, s.primary_receiver_fail, s.ant2_short,
                     s.ant1_short, s.ant2_disc, s.ant1_disc, 1'h0, s.float_heading,
                     s.heading_valid, s.tilt_valid, s.external_rx, s.time_valid,
                     s.doppler_valid, s.fix_status}, 2);
            end
            gnpf_pkg::GNPF_PKT_SATS: begin
                put(inertial_solution_in.horizontal_precision_dilution, 4);
                put(inertial_solution_in.vertical_precision_dilution, 4);
                put(inertial_solution_in.sat_counts, 5);
            end
            gnpf_pkg::GNPF_PKT_LOCAL_VEL: begin
                for (int j = 0; j < 3; j++) begin
                    put(inertial_solution_in.north_east_down_frame_vel[j*32+:32], 4);
                end
            end
            default: begin
                for (int j = 0; j < 3; j++) put(tri3[j*64+:64], 8);
                if (k == gnpf_pkg::GNPF_PKT_GRID_POS) begin
                    put(inertial_solution_in.zone_num, 1);
                    put(inertial_solution_in.zone_chr, 1);
                end
            end
        endcase
    endtask

    // One request, held until the edge that takes it
    task automatic send(input gnpf_pkg::gnpf_pkt_t k);
        @(negedge clk_in);
        while (req_ready_out !== 1'h1) @(negedge clk_in);
        req_valid_in = 1'h1;
        req_pkt_in = k;
        @(negedge clk_in);
        req_valid_in = 1'h0;
        chk(16'({req_ready_out, byte_valid_out}), 16'h0001);
    endtask

    // Wait for the packet to drain, then compare header and payload
    task automatic finish(input gnpf_row_t r);
        int t;
        t = 0;
        while (!(byte_valid_out === 1'h0 && host_cnt === r.len) && t < 400) begin
            @(negedge clk_in);
            t++;
        end
        chk(16'(t < 400), 16'h0001);
        chk(16'(last_seen), 16'h0001);
        last_seen = 0;
        chk(16'(pkt_id_out), 16'(r.id));
        chk(16'(pkt_len_out), 16'(r.len));
        chk(16'(host_cnt), 16'(exp_q.size()));
        for (int i = 0; i < exp_q.size(); i++) begin
            if (r.kind != gnpf_pkg::GNPF_PKT_RAW_RX)
                chk(16'(host_bytes[i*8+:8]), 16'(exp_q[i]));
            else if (i < gnpf_pkg::OFS_STATUS)
                chk(16'(host_bytes[i*8+:8]), 16'(exp_q[i]));
            else
                chk(16'(host_bytes[i*8+:8]), 16'(exp_q[i]));
        end
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        #100000;
        err_total++;
        $display("ERROR at %0t: watchdog seen %0h expected %0h", $time, 1'h1, 1'h0);
        tally_and_finish();
    end

    initial begin
        {rst_n_in, req_valid_in, host_stall} = 3'h0;
        req_pkt_in = gnpf_pkg::GNPF_PKT_RAW_RX;
        raw_rx_in = '0;
        inertial_solution_in = '0;
        err_total = 0;
        checked = 0;
        repeat (4) @(negedge clk_in);
        chk(16'({req_ready_out, byte_valid_out, byte_last_out}), 16'h0004);
        rst_n_in = 1'h1;
        // Table of all packet kinds
        for (int r = 0; r < 6; r++) begin
            fill(r);
            host_stall = rows[r].stall;
            build(rows[r].kind);
            send(rows[r].kind);
            finish(rows[r]);
            $display("Test table row %0d done", r);
        end
        // Walking status flag, then all flags set
        for (int j = 0; j < 16; j++) begin
            raw_rx_in.status = (j == 15) ? '1 : 15'(1 << j);
            build(gnpf_pkg::GNPF_PKT_RAW_RX);
            send(gnpf_pkg::GNPF_PKT_RAW_RX);
            finish(rows[0]);
        end
        $display("Test status word done");
        // Request and input change while busy are ignored
        host_stall = 1'h1;
        build(gnpf_pkg::GNPF_PKT_RAW_RX);
        send(gnpf_pkg::GNPF_PKT_RAW_RX);
        @(negedge clk_in);
        raw_rx_in.seconds = ~raw_rx_in.seconds;
        req_valid_in = 1'h1;
        req_pkt_in = gnpf_pkg::GNPF_PKT_SATS;
        repeat (5) @(negedge clk_in);
        chk(16'({req_ready_out, pkt_id_out}), 16'({1'h0, gnpf_pkg::ID_RAW_RX}));
        req_valid_in = 1'h0;
        finish(rows[0]);
        $display("Test busy refusal done");
        // Unused kind code is ignored
        @(negedge clk_in);
        req_valid_in = 1'h1;
        req_pkt_in = gnpf_pkg::gnpf_pkt_t'(3'h6);
        repeat (3) @(negedge clk_in);
        req_valid_in = 1'h0;
        chk(16'({req_ready_out, byte_valid_out}), 16'h0002);
        // Reset in mid packet, then a clean packet
        send(gnpf_pkg::GNPF_PKT_LOCAL_VEL);
        rst_n_in = 1'h0;
        @(negedge clk_in);
        chk(16'({req_ready_out, byte_valid_out, byte_last_out}), 16'h0004);
        rst_n_in = 1'h1;
        build(gnpf_pkg::GNPF_PKT_LOCAL_VEL);
        send(gnpf_pkg::GNPF_PKT_LOCAL_VEL);
        finish(rows[5]);
        $display("Test reset and odd code done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
